// ---- apmsc_host_model.sv ----
// host controller model: strap levels, self-tune command pin, sample clock
`timescale 1ns/10ps
module apmsc_host_model
  import apmsc_pkg::*;
(
  input  wire logic       clk_in,
  output logic      [1:0] range_out,
  output logic      [1:0] multi_out,
  output logic            cmd_out,
  output logic            sclk_out
);
  logic [1:0] div_q;

  // idle levels at time zero, command pin parked high
  initial begin
    range_out = APMSC_LVL_LOW;
    multi_out = APMSC_LVL_LOW;
    cmd_out   = 1'h1;
    sclk_out  = 1'h1;
    div_q     = 2'h0;
  end

  // sample clock at an eighth of clk, free running like an oscillator
  always @(posedge clk_in) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) sclk_out <= ~sclk_out;
  end

  // straps change just after a rising edge
  task automatic set_straps(input logic [1:0] r, input logic [1:0] m);
    @(posedge clk_in);
    range_out <= r;
    multi_out <= m;
  endtask : set_straps

  // low phase then high phase, counted in falling sample clock edges
  task automatic send_cmd(input int n_low, input int n_high);
    @(posedge clk_in);
    cmd_out <= 1'h0;
    repeat (n_low) @(negedge sclk_out);
    repeat (4) @(posedge clk_in); // margin so the last low tick is seen
    cmd_out <= 1'h1;
    repeat (n_high) @(negedge sclk_out);
  endtask : send_cmd
endmodule : apmsc_host_model

// ---- apmsc_pkg.sv ----
// constants, types and register map of the pin mode and self-tune control block
// Overview of operation
// (RULE_01) Firm range/control level: multi-function pin selects self-tune power-up wait length.
// (RULE_02) Floating range/control: multi-function pin is chip select; wait forced short.
// (RULE_03) Multi-function pin mid-level: dual-edge mode, first channel sampled twice, second ignored.
// (RULE_04) Analog input captured at each falling edge of the sample clock positive leg.
// (RULE_05) Self-tune active output high exactly while self-tune runs, low otherwise.
// (RULE_06) Non-extended control: range pin low selects small range, high selects large.
// (RULE_07) Range/control pin floating or mid-supply enables extended serial control.
// (RULE_08) Controller holds command pin low then high, each at least 80 cycles.
// (RULE_09) Output data strobe stops toggling while self-tune runs.
// (RULE_10) Controller treats output data invalid while self-tune active is high.
package apmsc_pkg;

  // three-level strap pin as reported by the pad level detector
  typedef enum logic [1:0] {
    APMSC_LVL_LOW  = 2'h0,
    APMSC_LVL_HIGH = 2'h1,
    APMSC_LVL_MID  = 2'h2,
    APMSC_LVL_OPEN = 2'h3
  } apmsc_level_type;

  // self-tune sequencer, gray coded along strap -> wait -> run -> ready
  typedef enum logic [1:0] {
    APMSC_ST_STRAP = 2'h0,
    APMSC_ST_WAIT  = 2'h1,
    APMSC_ST_RUN   = 2'h3,
    APMSC_ST_READY = 2'h2
  } apmsc_state_type;

  // decoded configuration carried as one bundle
  typedef struct packed {
    logic ext_ctrl;
    logic dual_edge;
    logic range_large;
    logic wait_long;
  } apmsc_mode_type;

  // register port
  localparam int          APMSC_ADDR_W    = 8;
  localparam int          APMSC_DATA_W    = 32;
  localparam logic [7:0]  APMSC_REG_STAT  = 8'h00;
  localparam logic [7:0]  APMSC_REG_CLR   = 8'h04;
  localparam logic [7:0]  APMSC_REG_EN    = 8'h08;
  localparam logic [7:0]  APMSC_REG_MODE  = 8'h0c;
  localparam logic [7:0]  APMSC_REG_CTRL  = 8'h10;
  localparam logic [31:0] APMSC_RD_UNMAP  = 32'h0000_0000;

  // event bits of status, clear and enable
  localparam int          APMSC_EV_W      = 3;
  localparam int          APMSC_EV_DONE   = 0;
  localparam int          APMSC_EV_START  = 1;
  localparam int          APMSC_EV_CMDIGN = 2;

  // control register fields and reset value
  localparam int          APMSC_CTRL_CAPEN = 0;
  localparam int          APMSC_CTRL_SWCAL = 1;
  localparam logic [1:0]  APMSC_CTRL_RST   = 2'h1;

  // mode register fields
  localparam int          APMSC_MODE_STATE = 4;
  localparam int          APMSC_MODE_ACT   = 6;

  // timing: command pin phases in sample clock cycles, strap settle in clk cycles
  localparam int          APMSC_CMD_MIN_CYC = 80;
  localparam int          APMSC_STRAP_CYC   = 3;
  localparam logic [1:0]  APMSC_STRAP_LAST  = 2'(APMSC_STRAP_CYC - 1);

  // default wait and run lengths in sample clock cycles
  localparam int          APMSC_WAIT_SHORT_DEF = 256;
  localparam int          APMSC_WAIT_LONG_DEF  = 65536;
  localparam int          APMSC_RUN_DEF        = 1024;
  localparam int          APMSC_CNT_W          = 18;
  localparam int          APMSC_SAMPLE_W       = 8;

endpackage : apmsc_pkg

// ---- apmsc_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module apmsc_sync #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : apmsc_sync

// ---- apmsc_top.sv ----
// pin strap decode, sample capture, output strobe and self-tune sequencer
`timescale 1ns/10ps
module apmsc_top
  import apmsc_pkg::*;
#(
  parameter int WAIT_SHORT = APMSC_WAIT_SHORT_DEF,
  parameter int WAIT_LONG  = APMSC_WAIT_LONG_DEF,
  parameter int RUN_CYC    = APMSC_RUN_DEF
) (
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  input  wire logic [1:0]                range_ctrl_level_in,
  input  wire logic [1:0]                multi_pin_level_in,
  input  wire logic                      selftune_cmd_in,
  input  wire logic                      sample_clk_p_in,
  input  wire logic [APMSC_SAMPLE_W-1:0] ain_first_in,
  input  wire logic [APMSC_SAMPLE_W-1:0] ain_second_in,
  input  wire logic [APMSC_ADDR_W-1:0]   reg_addr_in,
  input  wire logic [APMSC_DATA_W-1:0]   reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [APMSC_DATA_W-1:0]   reg_rdata_out,
  output logic                           irq_out,
  output logic                           selftune_active_out,
  output logic                           output_data_strobe_out,
  output logic                           serial_chip_select_n_out,
  output apmsc_mode_type                 mode_out,
  output logic [APMSC_SAMPLE_W-1:0]      lane_a_out,
  output logic [APMSC_SAMPLE_W-1:0]      lane_b_out,
  output logic                           sample_valid_out
);

  // refuse lengths the counters cannot hold
  if (WAIT_SHORT < 1 || WAIT_LONG < WAIT_SHORT || RUN_CYC < 1 ||
      WAIT_LONG >= (1 << APMSC_CNT_W) || RUN_CYC >= (1 << APMSC_CNT_W)) begin : g_chk
    $error("apmsc_top: wait or run length out of range");
  end

  // floating and mid-supply both count as the third level
  function automatic logic lvl_is_mid(input logic [1:0] lvl);
    lvl_is_mid = (lvl == APMSC_LVL_MID) || (lvl == APMSC_LVL_OPEN);
  endfunction : lvl_is_mid

  logic [1:0]            range_lvl_s;
  logic [1:0]            multi_lvl_s;
  logic                  cmd_s;
  logic                  sclk_s;
  logic                  sclk_q;
  logic                  fall_tick;
  logic                  rise_tick;
  apmsc_state_type       state_q;
  logic [1:0]            strap_cnt_q;
  logic [APMSC_CNT_W-1:0] cnt_q;
  logic                  wait_long_q;
  logic [6:0]            low_cnt_q;
  logic [6:0]            high_cnt_q;
  logic                  low_met_q;
  logic                  cmd_start;
  logic                  start_cal;
  logic                  cal_done;
  logic [1:0]            ctrl_q;
  logic [APMSC_EV_W-1:0] stat_q;
  logic [APMSC_EV_W-1:0] en_q;
  logic [APMSC_EV_W-1:0] ev;
  logic                  ext_ctrl;
  logic                  dual_edge;

  // straps, command pin and sample clock come from outside, two flops each
  apmsc_sync #(.WIDTH(6), .RST_VAL(6'h01)) apmsc_sync_inst (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  ({range_ctrl_level_in, multi_pin_level_in, selftune_cmd_in, sample_clk_p_in}),
    .sync_out  ({range_lvl_s, multi_lvl_s, cmd_s, sclk_s})
  );

  // edge detect on the synchronised sample clock leg
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  assign fall_tick = sclk_q & ~sclk_s;   // sampling instant
  assign rise_tick = ~sclk_q & sclk_s;

  // live strap decode
  assign ext_ctrl  = lvl_is_mid(range_lvl_s);  // RULE_07
  assign dual_edge = lvl_is_mid(multi_lvl_s);  // RULE_03

  always_comb begin
    mode_out             = '0;
    mode_out.ext_ctrl    = ext_ctrl;
    mode_out.dual_edge   = dual_edge;
    // extended control owns range through the serial port, pin reads small here
    mode_out.range_large = ~ext_ctrl & (range_lvl_s == APMSC_LVL_HIGH);  // RULE_06
    mode_out.wait_long   = wait_long_q;
  end

  // pin acts as chip select only under extended control, active low
  assign serial_chip_select_n_out = ~(ext_ctrl & (multi_lvl_s == APMSC_LVL_LOW));  // RULE_02

  // command pin: a long low phase arms, a long high phase then fires
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_cnt_q  <= '0;
      high_cnt_q <= '0;
      low_met_q  <= 1'b0;
    end else if (fall_tick) begin
      if (!cmd_s) begin
        high_cnt_q <= '0;
        if (low_cnt_q == 7'(APMSC_CMD_MIN_CYC - 1)) begin
          low_met_q <= 1'b1;  // RULE_08
        end else begin
          low_cnt_q <= low_cnt_q + 7'h01;
        end
      end else begin
        low_cnt_q <= '0;
        if (cmd_start) begin
          low_met_q  <= 1'b0;
          high_cnt_q <= '0;
        end else if (low_met_q) begin
          high_cnt_q <= high_cnt_q + 7'h01;
        end
      end
    end
  end

  assign cmd_start = fall_tick & cmd_s & low_met_q &
                     (high_cnt_q == 7'(APMSC_CMD_MIN_CYC - 1));  // RULE_08
  assign start_cal = (state_q == APMSC_ST_READY) &
                     (cmd_start | ctrl_q[APMSC_CTRL_SWCAL]);
  assign cal_done  = (state_q == APMSC_ST_RUN) & fall_tick &
                     (cnt_q == APMSC_CNT_W'(RUN_CYC - 1));

  // self-tune sequencer: straps settle, power-up wait, run, then on command
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q     <= APMSC_ST_STRAP;
      strap_cnt_q <= '0;
      cnt_q       <= '0;
      wait_long_q <= 1'b0;
    end else begin
      unique case (state_q)
        APMSC_ST_STRAP: begin
          strap_cnt_q <= strap_cnt_q + 2'h1;
          if (strap_cnt_q == APMSC_STRAP_LAST) begin
            // floating control forces the short wait
            wait_long_q <= ~ext_ctrl & (multi_lvl_s == APMSC_LVL_HIGH);  // RULE_01 RULE_02
            state_q     <= APMSC_ST_WAIT;
          end
        end
        APMSC_ST_WAIT: begin
          if (fall_tick) begin
            if (cnt_q == APMSC_CNT_W'((wait_long_q ? WAIT_LONG : WAIT_SHORT) - 1)) begin
              cnt_q   <= '0;
              state_q <= APMSC_ST_RUN;  // RULE_01
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        APMSC_ST_RUN: begin
          if (cal_done) begin
            cnt_q   <= '0;
            state_q <= APMSC_ST_READY;
          end else if (fall_tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        APMSC_ST_READY: begin
          if (start_cal) begin
            cnt_q   <= '0;
            state_q <= APMSC_ST_RUN;
          end
        end
      endcase
    end
  end

  assign selftune_active_out = (state_q == APMSC_ST_RUN);  // RULE_05

  // capture; output stays frozen and unflagged while self-tune runs
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lane_a_out       <= '0;
      lane_b_out       <= '0;
      sample_valid_out <= 1'b0;
    end else begin
      sample_valid_out <= 1'b0;
      if (ctrl_q[APMSC_CTRL_CAPEN] && !selftune_active_out) begin
        if (fall_tick) begin
          lane_a_out       <= ain_first_in;  // RULE_04
          sample_valid_out <= 1'b1;
          if (!dual_edge) begin
            lane_b_out <= ain_second_in;
          end
        end else if (rise_tick && dual_edge) begin
          lane_b_out <= ain_first_in;  // RULE_03
        end
      end
    end
  end

  // strobe at half the sample rate, parked low during self-tune
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      output_data_strobe_out <= 1'b0;
    end else if (selftune_active_out) begin
      output_data_strobe_out <= 1'b0;  // RULE_09
    end else if (fall_tick) begin
      output_data_strobe_out <= ~output_data_strobe_out;
    end
  end

  // control register, the software request bit is self-clearing
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= APMSC_CTRL_RST;
    end else if (reg_wr_in && reg_addr_in == APMSC_REG_CTRL) begin
      ctrl_q <= reg_wdata_in[1:0];
    end else if (start_cal || state_q != APMSC_ST_READY) begin
      ctrl_q[APMSC_CTRL_SWCAL] <= 1'b0;
    end
  end

  // events: done, start, and a command fired outside ready that was dropped
  assign ev[APMSC_EV_DONE]   = cal_done;
  assign ev[APMSC_EV_START]  = start_cal;
  assign ev[APMSC_EV_CMDIGN] = cmd_start & (state_q != APMSC_ST_READY);

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stat_q <= '0;
    end else if (reg_wr_in && reg_addr_in == APMSC_REG_CLR) begin
      stat_q <= (stat_q & ~reg_wdata_in[APMSC_EV_W-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_q <= '0;
    end else if (reg_wr_in && reg_addr_in == APMSC_REG_EN) begin
      en_q <= reg_wdata_in[APMSC_EV_W-1:0];
    end
  end

  assign irq_out = |(stat_q & en_q);

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        APMSC_REG_STAT: reg_rdata_out <= {29'h0, stat_q};
        APMSC_REG_EN:   reg_rdata_out <= {29'h0, en_q};
        APMSC_REG_MODE: reg_rdata_out <= {25'h0, selftune_active_out, state_q, mode_out};
        APMSC_REG_CTRL: reg_rdata_out <= {30'h0, ctrl_q};
        default:        reg_rdata_out <= APMSC_RD_UNMAP;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // checks
  a_active_holds: assert property (@(posedge clk_in) disable iff (!resetn_in)
    selftune_active_out && !cal_done |=> selftune_active_out)  // RULE_05
    else $error("active output dropped before self-tune finished");

  a_run_length: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(selftune_active_out) |-> cnt_q == '0)  // RULE_05
    else $error("run counter not cleared at start");

  a_strobe_frozen: assert property (@(posedge clk_in) disable iff (!resetn_in)
    selftune_active_out ##1 selftune_active_out |-> !output_data_strobe_out)  // RULE_09
    else $error("strobe toggles during self-tune");

  a_range_pin_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !lvl_is_mid(range_lvl_s) |-> mode_out.range_large == range_lvl_s[0])  // RULE_06
    else $error("range select does not follow pin");

  a_ext_on_mid: assert property (@(posedge clk_in) disable iff (!resetn_in)
    mode_out.ext_ctrl == lvl_is_mid(range_lvl_s))  // RULE_07
    else $error("extended control decode wrong");

  a_wait_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_q == APMSC_ST_STRAP && strap_cnt_q == APMSC_STRAP_LAST
    |=> wait_long_q == (!$past(ext_ctrl) && $past(multi_lvl_s) == APMSC_LVL_HIGH))  // RULE_01
    else $error("wait select latched wrong");

  a_short_when_ext: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_q == APMSC_ST_STRAP && strap_cnt_q == APMSC_STRAP_LAST && ext_ctrl
    |=> !wait_long_q)  // RULE_02
    else $error("long wait allowed under extended control");

  a_dual_edge_lane: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rise_tick && dual_edge && ctrl_q[APMSC_CTRL_CAPEN] && !selftune_active_out
    |=> lane_b_out == $past(ain_first_in))  // RULE_03
    else $error("dual-edge lane not fed from first input");

  a_capture_fall: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fall_tick && ctrl_q[APMSC_CTRL_CAPEN] && !selftune_active_out
    |=> sample_valid_out && lane_a_out == $past(ain_first_in))  // RULE_04
    else $error("sample not captured on falling edge");

  a_cmd_starts_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cmd_start && state_q == APMSC_ST_READY |=> selftune_active_out)  // RULE_08
    else $error("command did not start self-tune");

endmodule : apmsc_top

// ---- test_apmsc_top.sv ----
// self-checking bench for the pin mode and self-tune control block
`timescale 1ns/10ps
module test_apmsc_top
  import apmsc_pkg::*;
;
  localparam int WS = 4;
  localparam int WL = 8;
  localparam int RC = 8;
  logic                      clk_in;
  logic                      resetn_in;
  logic [1:0]                range_lvl;
  logic [1:0]                multi_lvl;
  logic                      cmd;
  logic                      sclk;
  logic [APMSC_SAMPLE_W-1:0] ain_first;
  logic [APMSC_SAMPLE_W-1:0] ain_second;
  logic [APMSC_ADDR_W-1:0]   reg_addr;
  logic [APMSC_DATA_W-1:0]   reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [APMSC_DATA_W-1:0]   rdata;
  logic                      irq;
  logic                      active;
  logic                      strobe;
  logic                      cs_n;
  apmsc_mode_type            mode;
  logic [APMSC_SAMPLE_W-1:0] lane_a;
  logic [APMSC_SAMPLE_W-1:0] lane_b;
  logic                      valid;
  int                        err_total;
  int                        n_compared;
  logic [31:0]               w;
  int                        d;

  apmsc_host_model host_inst (.clk_in(clk_in), .range_out(range_lvl), .multi_out(multi_lvl),
    .cmd_out(cmd), .sclk_out(sclk));

  // short counts keep the run brief
  apmsc_top #(.WAIT_SHORT(WS), .WAIT_LONG(WL), .RUN_CYC(RC)) apmsc_top_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .range_ctrl_level_in(range_lvl),
    .multi_pin_level_in(multi_lvl), .selftune_cmd_in(cmd), .sample_clk_p_in(sclk),
    .ain_first_in(ain_first), .ain_second_in(ain_second), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .irq_out(irq), .selftune_active_out(active),
    .output_data_strobe_out(strobe), .serial_chip_select_n_out(cs_n), .mode_out(mode),
    .lane_a_out(lane_a), .lane_b_out(lane_b), .sample_valid_out(valid));

  // 100 MHz clock
  initial clk_in = 1'h0;
  always #5 clk_in = ~clk_in;

  task automatic end_of_test;
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("wrong value at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_range

  // one-cycle strobes, a gap cycle between accesses
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_in);
    reg_wr    <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd   <= 1'h0;
    #1;
    v = rdata;
  endtask : reg_read

  // cycles from reset release to self-tune start, bounded
  task automatic apply_reset(input logic [1:0] r, input logic [1:0] m, output int n);
    @(posedge clk_in);
    resetn_in <= 1'h0;
    host_inst.set_straps(r, m);
    repeat (4) @(posedge clk_in);
    #1;
    check_bit(active, 1'h0);
    check_bit(cs_n, 1'h1);
    @(posedge clk_in);
    resetn_in <= 1'h1;
    n = 0;
    while (active !== 1'h1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : apply_reset

  // run length, frozen strobe and no captures while self-tune runs
  task automatic t_run;
    int n;
    int t;
    n = 0;
    t = 0;
    // strobe is parked low for the whole run
    while (active === 1'h1 && n < 500) begin
      @(posedge clk_in);
      #1;
      n++;
      if (strobe !== 1'h0) t++;
      check_bit(valid, 1'h0);
    end
    check_range(n, RC * 8 - 8, RC * 8 + 8);
    check_range(t, 0, 0);
    reg_read(APMSC_REG_STAT, w);
    check_bit(w[APMSC_EV_DONE], 1'h1);
  endtask : t_run

  // register table reset values, access kinds, unmapped place
  task automatic t_regs;
    reg_read(APMSC_REG_MODE, w);
    check_word(w, 32'(APMSC_ST_READY) << APMSC_MODE_STATE);
    reg_write(APMSC_REG_MODE, 32'hffff_ffff);
    reg_read(APMSC_REG_MODE, w);
    check_word(w, 32'(APMSC_ST_READY) << APMSC_MODE_STATE);
    reg_read(APMSC_REG_CTRL, w);
    check_word(w, 32'h0000_0001);
    reg_read(APMSC_REG_EN, w);
    check_word(w, 32'h0000_0000);
    reg_write(8'h14, 32'hffff_ffff);
    reg_read(8'h14, w);
    check_word(w, APMSC_RD_UNMAP);
    reg_write(APMSC_REG_CTRL, 32'h0000_0000);
    reg_read(APMSC_REG_CTRL, w);
    check_word(w, 32'h0000_0000);
    reg_write(APMSC_REG_CTRL, 32'h0000_0001);
  endtask : t_regs

  // strap decode table with the multi-function pin low, then mid and open
  task automatic t_modes;
    for (int r = 0; r < 4; r++) begin
      host_inst.set_straps(2'(r), APMSC_LVL_LOW);
      repeat (4) @(posedge clk_in);
      #1;
      check_bit(mode.ext_ctrl, r >= 2);
      check_bit(mode.range_large, r == 1);
      check_bit(cs_n, r < 2);
      check_bit(mode.dual_edge, 1'h0);
    end
    for (int m = 2; m < 4; m++) begin
      host_inst.set_straps(APMSC_LVL_HIGH, 2'(m));
      repeat (4) @(posedge clk_in);
      #1;
      check_bit(mode.dual_edge, 1'h1);
    end
  endtask : t_modes

  // capture at falling sample edge, then dual-edge capture of first channel
  task automatic t_capture;
    int n;
    host_inst.set_straps(APMSC_LVL_LOW, APMSC_LVL_LOW);
    ain_first  <= 8'h5a;
    ain_second <= 8'ha5;
    @(negedge sclk);
    n = 0;
    while (valid !== 1'h1 && n < 20) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check_range(n, 3, 5);
    check_word(32'(lane_a), 32'h5a);
    check_word(32'(lane_b), 32'ha5);
    host_inst.set_straps(APMSC_LVL_LOW, APMSC_LVL_MID);
    ain_first  <= 8'h3c;
    ain_second <= 8'hc3;
    repeat (4) @(posedge clk_in);
    @(posedge sclk);
    repeat (6) @(posedge clk_in);
    #1;
    check_word(32'(lane_b), 32'h3c);
  endtask : t_capture

  // interrupt enable, mask, clear, then on-command self-tune
  task automatic t_irq_cmd;
    reg_write(APMSC_REG_EN, 32'h1);
    #1;
    check_bit(irq, 1'h1);
    reg_write(APMSC_REG_EN, 32'h0);
    #1;
    check_bit(irq, 1'h0);
    reg_write(APMSC_REG_EN, 32'h3);
    reg_write(APMSC_REG_CLR, 32'h7);
    #1;
    check_bit(irq, 1'h0);
    reg_read(APMSC_REG_STAT, w);
    check_word(w, 32'h0);
    host_inst.send_cmd(80, 80);
    d = 0;
    while (active !== 1'h1 && d < 100) begin
      @(posedge clk_in);
      #1;
      d++;
    end
    check_bit(active, 1'h1);
    check_bit(irq, 1'h1);
    t_run();
    // software request starts a run on the next cycle and clears itself
    reg_write(APMSC_REG_CTRL, 32'h3);
    @(posedge clk_in);
    #1;
    check_bit(active, 1'h1);
    t_run();
    reg_read(APMSC_REG_CTRL, w);
    check_word(w, 32'h1);
  endtask : t_irq_cmd

  // watchdog cuts a hang short
  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    end_of_test();
  end

  // main sequence
  initial begin
    resetn_in  = 1'h0;
    ain_first  = 8'h00;
    ain_second = 8'h00;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'h0;
    reg_rd     = 1'h0;
    err_total  = 0;
    n_compared = 0;
    apply_reset(APMSC_LVL_LOW, APMSC_LVL_LOW, d);
    check_range(d, WS * 8 - 4, WS * 8 + 4);
    check_bit(mode.wait_long, 1'h0);
    t_run();
    t_regs();
    apply_reset(APMSC_LVL_HIGH, APMSC_LVL_HIGH, d);
    check_range(d, WL * 8 - 4, WL * 8 + 4);
    check_bit(mode.wait_long, 1'h1);
    t_run();
    apply_reset(APMSC_LVL_OPEN, APMSC_LVL_HIGH, d);
    check_range(d, WS * 8 - 4, WS * 8 + 4);
    check_bit(mode.wait_long, 1'h0);
    t_run();
    t_modes();
    t_capture();
    t_irq_cmd();
    end_of_test();
  end
endmodule : test_apmsc_top
